// *** verilog/tcwg_pkg.sv ***
// Package with register map, field layout and mode types of the compare waveform generator.
package tcwg_pkg;
   localparam int unsigned NUM_CH = 3;
   localparam int unsigned COUNT_W = 16;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned PRESC_W = 10;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PERIOD = 8'h04;
   localparam logic [7:0] OFF_COUNT = 8'h08;
   localparam logic [7:0] OFF_COMPARE_VALUE_ZERO = 8'h0c;
   localparam logic [7:0] OFF_CMP1 = 8'h10;
   localparam logic [7:0] OFF_CMP2 = 8'h14;
   localparam logic [7:0] OFF_BUF0 = 8'h18;
   localparam logic [7:0] OFF_BUF1 = 8'h1c;
   localparam logic [7:0] OFF_BUF2 = 8'h20;
   localparam logic [7:0] OFF_STATUS = 8'h24;
   localparam logic [7:0] OFF_INTEN = 8'h28;
   localparam logic [7:0] OFF_PIN = 8'h2c;

   // Field positions in the status and pin registers.
   localparam int unsigned ST_FLAG_LSB = 0;
   localparam int unsigned ST_VALID_LSB = 3;
   localparam int unsigned ST_WAVE_LSB = 6;
   localparam int unsigned PIN_INV_LSB = 0;
   localparam int unsigned PIN_OUT_LSB = 3;
   localparam int unsigned PIN_DIR_LSB = 6;

   // Reset values.
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam logic [15:0] CMP_RST = 16'h0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] BOTTOM = 16'h0000;

   typedef enum logic [1:0] {
      WG_NORMAL,
      WG_FREQ,
      WG_SINGLE,
      WG_DUAL
   } tcwg_mode_e;

   // Control register layout, least significant field last.
   typedef struct packed {
      logic [2:0] channel_output_enable;
      logic update_lock;
      logic count_down;
      tcwg_mode_e waveform_mode_select;
      logic [2:0] prescale_select;
      logic enable;
   } tcwg_ctrl_s;

   localparam int unsigned CTRL_W = $bits(tcwg_ctrl_s);
   localparam logic [10:0] CTRL_RST = 11'h000;

   // Pin configuration group handed to the pin override path.
   typedef struct packed {
      logic [2:0] pin_direction;
      logic [2:0] port_out;
      logic [2:0] pin_invert_enable;
   } tcwg_pin_s;

   localparam logic [8:0] PIN_RST = 9'h000;
endpackage

// *** verilog/tcwg_top.sv ***
// Compare channels, waveform generation and pin override of a 16-bit timer, APB slave.
//
// What this block does
// - Each channel compares counter value with its compare value, signalling match when equal.
// - Match sets channel flag next clock; request raised only if channel interrupt enabled.
// - On update, valid buffer copies into compare value, used from next count.
// - Waveform replaces port output only when channel enabled and waveform mode selected.
// - Pin invert enable inverts the waveform driven onto the pin.
// - Frequency mode uses compare zero as period, counter restarts after it.
// - Frequency mode toggles each enabled channel output on every compare match.
// - Frequency output is clock over twice divider times compare zero plus one.
// - Channels one and two give phase-offset outputs when below compare zero.
// - Single-slope mode counts up from BOTTOM to period, then restarts.
// - Single-slope output set at BOTTOM, cleared on compare match.
// - Single-slope compare at BOTTOM gives low, above period gives high.
// - Period sets resolution, from two bits at three to sixteen bits.
// - Single-slope frequency is clock over divider times period plus one.
// - Dual-slope counts up from BOTTOM to period and back down repeatedly.
// - Dual-slope output set at BOTTOM, cleared matching up, set matching down.
// - Dual-slope compare at BOTTOM holds low, at period holds high.
// - Dual-slope frequency is clock over twice divider times period.
// - Update at BOTTOM transfers valid buffers unless update lock is set.
// - Buffer valid set on buffer write, cleared when update transfers it.
// - BOTTOM is detected when counter value becomes zero.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module tcwg_top (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   output logic [2:0] compare_match_pulse,
   output logic compare_irq
);
   localparam int unsigned N = tcwg_pkg::NUM_CH;

   // Prescaler mask: a tick comes when all masked low bits are ones.
   function automatic logic [9:0] div_mask(input logic [2:0] sel);
      case (sel)
         3'h0: div_mask = 10'h000;
         3'h1: div_mask = 10'h001;
         3'h2: div_mask = 10'h003;
         3'h3: div_mask = 10'h007;
         3'h4: div_mask = 10'h00f;
         3'h5: div_mask = 10'h03f;
         3'h6: div_mask = 10'h0ff;
         default: div_mask = 10'h3ff;
      endcase
   endfunction

   // Compare index of a compare or buffer offset, one-hot.
   function automatic logic [2:0] ch_hit(input logic [7:0] a, input logic [7:0] base);
      ch_hit = {a == (base + 8'h08), a == (base + 8'h04), a == base};
   endfunction

   tcwg_pkg::tcwg_ctrl_s ctrl_r;
   tcwg_pkg::tcwg_pin_s pin_cfg_r;
   logic [15:0] period_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic dual_down_r;
   logic dual_down_nxt;
   logic [9:0] presc_r;
   logic count_new_r;
   logic [15:0] cmp_r [N];
   logic [15:0] buf_r [N];
   logic [N-1:0] valid_r;
   logic [N-1:0] flag_r;
   logic [N-1:0] inten_r;
   logic [N-1:0] wave_r;
   logic [31:0] prdata_r;

   // Bus decode.
   wire setup_phase = psel & ~penable;
   wire access_wr = psel & penable & pwrite;
   wire [2:0] hit_cmp = ch_hit(paddr, tcwg_pkg::OFF_COMPARE_VALUE_ZERO);
   wire [2:0] hit_buf = ch_hit(paddr, tcwg_pkg::OFF_BUF0);
   wire hit_ctrl = paddr == tcwg_pkg::OFF_CTRL;
   wire hit_period = paddr == tcwg_pkg::OFF_PERIOD;
   wire hit_count = paddr == tcwg_pkg::OFF_COUNT;
   wire hit_status = paddr == tcwg_pkg::OFF_STATUS;
   wire hit_inten = paddr == tcwg_pkg::OFF_INTEN;
   wire hit_pin = paddr == tcwg_pkg::OFF_PIN;
   wire mapped = hit_ctrl | hit_period | hit_count | hit_status | hit_inten | hit_pin
      | (|hit_cmp) | (|hit_buf);
   wire wr_ctrl = access_wr & hit_ctrl;
   wire wr_period = access_wr & hit_period;
   wire wr_count = access_wr & hit_count;
   wire wr_status = access_wr & hit_status;
   wire wr_inten = access_wr & hit_inten;
   wire wr_pin = access_wr & hit_pin;
   wire [2:0] wr_cmp = hit_cmp & {N{access_wr}};
   wire [2:0] wr_buf = hit_buf & {N{access_wr}};

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_r;

   // Counter sequence.
   wire mode_freq = ctrl_r.waveform_mode_select == tcwg_pkg::WG_FREQ;
   wire mode_single = ctrl_r.waveform_mode_select == tcwg_pkg::WG_SINGLE;
   wire mode_dual = ctrl_r.waveform_mode_select == tcwg_pkg::WG_DUAL;
   wire wave_mode = ctrl_r.waveform_mode_select != tcwg_pkg::WG_NORMAL;
   wire [9:0] mask = div_mask(ctrl_r.prescale_select);
   wire tick = ctrl_r.enable & ((presc_r & mask) == mask);
   wire [15:0] top = mode_freq ? cmp_r[0] : period_r;
   wire going_down = mode_dual ? dual_down_r : ctrl_r.count_down;
   wire at_bottom = count_r == tcwg_pkg::BOTTOM;
   wire at_top = count_r == top;
   wire update_cond = tick & ~wr_count & (count_nxt == tcwg_pkg::BOTTOM) & ~ctrl_r.update_lock;

   always_comb begin
      count_nxt = count_r;
      dual_down_nxt = dual_down_r;
      if (wr_count) begin
         count_nxt = pwdata[15:0];
      end else if (tick) begin
         if (mode_dual) begin
            if (!dual_down_r && at_top) begin
               dual_down_nxt = 1'b1;
               count_nxt = at_bottom ? count_r : count_r - 16'h0001;
            end else if (dual_down_r && at_bottom) begin
               dual_down_nxt = 1'b0;
               count_nxt = at_top ? count_r : count_r + 16'h0001;
            end else begin
               count_nxt = dual_down_r ? count_r - 16'h0001 : count_r + 16'h0001;
            end
         end else if (going_down) begin
            count_nxt = at_bottom ? top : count_r - 16'h0001;
         end else begin
            count_nxt = at_top ? tcwg_pkg::BOTTOM : count_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         presc_r <= 10'h000;
         count_r <= tcwg_pkg::COUNT_RST;
         dual_down_r <= 1'b0;
         count_new_r <= 1'b0;
      end else begin
         presc_r <= ctrl_r.enable ? presc_r + 10'h001 : 10'h000;
         count_r <= count_nxt;
         dual_down_r <= dual_down_nxt;
         count_new_r <= tick | wr_count;
      end
   end

   // Configuration registers.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= tcwg_pkg::CTRL_RST;
         period_r <= tcwg_pkg::PERIOD_RST;
         inten_r <= 3'h0;
         pin_cfg_r <= tcwg_pkg::PIN_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= pwdata[tcwg_pkg::CTRL_W-1:0];
         end
         if (wr_period) begin
            period_r <= pwdata[15:0];
         end
         if (wr_inten) begin
            inten_r <= pwdata[2:0];
         end
         if (wr_pin) begin
            pin_cfg_r <= pwdata[8:0];
         end
      end
   end

   // Read data is latched in the setup phase so the access phase needs no wait.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[tcwg_pkg::CTRL_W-1:0] = ctrl_r;
      end
      if (hit_period) begin
         rd_mux[15:0] = period_r;
      end
      if (hit_count) begin
         rd_mux[15:0] = count_r;
      end
      for (int i = 0; i < N; i++) begin
         if (hit_cmp[i]) begin
            rd_mux[15:0] = cmp_r[i];
         end
         if (hit_buf[i]) begin
            rd_mux[15:0] = buf_r[i];
         end
      end
      if (hit_status) begin
         rd_mux[8:0] = {wave_r, valid_r, flag_r};
      end
      if (hit_inten) begin
         rd_mux[2:0] = inten_r;
      end
      if (hit_pin) begin
         rd_mux[8:0] = pin_cfg_r;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata_r <= rd_mux;
      end
   end

   // Per-channel compare, buffering, flags and waveform.
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_ch
         wire match = count_r == cmp_r[g];
         wire match_evt = match & count_new_r;
         wire en = ctrl_r.channel_output_enable[g];
         wire cmp_zero = cmp_r[g] == tcwg_pkg::BOTTOM;
         wire cmp_top = cmp_r[g] == period_r;
         logic wave_nxt;

         assign compare_match_pulse[g] = match_evt;

         always_comb begin
            wave_nxt = wave_r[g];
            if (en && count_new_r) begin
               case (ctrl_r.waveform_mode_select)
                  tcwg_pkg::WG_FREQ: begin
                     if (match) begin
                        wave_nxt = ~wave_r[g];
                     end
                  end
                  tcwg_pkg::WG_SINGLE: begin
                     // Clear after set, so a compare at BOTTOM keeps the line low.
                     if (at_bottom) begin
                        wave_nxt = 1'b1;
                     end
                     if (match) begin
                        wave_nxt = 1'b0;
                     end
                  end
                  tcwg_pkg::WG_DUAL: begin
                     if (cmp_zero) begin
                        wave_nxt = 1'b0;
                     end else if (cmp_top) begin
                        wave_nxt = 1'b1;
                     end else if (at_bottom) begin
                        wave_nxt = 1'b1;
                     end else if (match) begin
                        wave_nxt = dual_down_r;
                     end
                  end
                  default: begin
                     wave_nxt = wave_r[g];
                  end
               endcase
            end
         end

         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               cmp_r[g] <= tcwg_pkg::CMP_RST;
               buf_r[g] <= tcwg_pkg::CMP_RST;
               valid_r[g] <= 1'b0;
               flag_r[g] <= 1'b0;
               wave_r[g] <= 1'b0;
            end else begin
               if (wr_cmp[g]) begin
                  cmp_r[g] <= pwdata[15:0];
               end else if (update_cond && valid_r[g]) begin
                  cmp_r[g] <= buf_r[g];
               end
               if (wr_buf[g]) begin
                  buf_r[g] <= pwdata[15:0];
               end
               // A buffer write in the transfer cycle keeps the valid flag set.
               if (wr_buf[g]) begin
                  valid_r[g] <= 1'b1;
               end else if (update_cond) begin
                  valid_r[g] <= 1'b0;
               end
               // Write one to clear; a match in the same cycle wins.
               if (match_evt) begin
                  flag_r[g] <= 1'b1;
               end else if (wr_status && pwdata[tcwg_pkg::ST_FLAG_LSB + g]) begin
                  flag_r[g] <= 1'b0;
               end
               wave_r[g] <= wave_nxt;
            end
         end

         // Pin override path; the pin drives only when software set it as output.
         wire override = en & wave_mode;
         wire level = override ? wave_r[g] : pin_cfg_r.port_out[g];
         assign pin_out[g] = level ^ pin_cfg_r.pin_invert_enable[g];
         assign pin_oe[g] = pin_cfg_r.pin_direction[g];
      end
   endgenerate

   assign compare_irq = |(flag_r & inten_r);

endmodule

`default_nettype wire

// *** dv/tcwg_pin_model.sv ***
// Port pin pad model that resolves the override path onto the pin level.
`timescale 1ns/100ps
`default_nettype none
module tcwg_pin_model (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   output logic [2:0] pin_level
);
   // An input pin floats to its pull-up, so a waveform never shows until direction is set.
   assign pin_level = (pin_out & pin_oe) | ~pin_oe;
endmodule
`default_nettype wire

// *** dv/tcwg_sva.sv ***
// Port checker for the compare waveform generator top.
`timescale 1ns/100ps
`default_nettype none
module tcwg_chk (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] compare_match_pulse,
   input wire logic compare_irq
);
   logic [10:0] ctrl_r;
   logic [8:0] pin_r;
   wire logic wr_acc = psel && penable && pwrite;
   // Shadows of control and pin setup, rebuilt from bus writes.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= 11'h000;
         pin_r <= 9'h000;
      end else if (wr_acc && paddr == tcwg_pkg::OFF_CTRL) begin
         ctrl_r <= pwdata[10:0];
      end else if (wr_acc && paddr == tcwg_pkg::OFF_PIN) begin
         pin_r <= pwdata[8:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_oe;
      pin_oe == pin_r[8:6];
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable differs from direction");
   property p_norm;
      ctrl_r[5:4] == 2'h0 |-> pin_out == (pin_r[5:3] ^ pin_r[2:0]);
   endproperty
   a_norm: assert property (p_norm) else $error("normal mode overrides pin");
   property p_en;
      ((pin_out ^ pin_r[5:3] ^ pin_r[2:0]) & ~ctrl_r[10:8]) == 3'h0;
   endproperty
   a_en: assert property (p_en) else $error("disabled channel overrides pin");
   property p_hold;
      !ctrl_r[0] && !$past(ctrl_r[0]) && !$past(psel) && !$past(psel, 2) |-> $stable(pin_out);
   endproperty
   a_hold: assert property (p_hold) else $error("pin moved while stopped");
   property p_nomatch;
      !ctrl_r[0] && !$past(ctrl_r[0]) && !$past(psel) |-> compare_match_pulse == 3'h0;
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("match while stopped");
   property p_irq_rise;
      $rose(compare_irq) |-> $past(|compare_match_pulse) || $past(wr_acc);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without match");
   property p_irq_fall;
      $fell(compare_irq) |-> $past(wr_acc);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
   property p_clear;
      ctrl_r[5:4] == 2'h2 && !penable && |(compare_match_pulse & ctrl_r[10:8])
         |=> ((pin_out ^ pin_r[2:0]) & $past(compare_match_pulse & ctrl_r[10:8])) == 3'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("match did not clear output");
endmodule
bind tcwg_top tcwg_chk u_chk (.clock(clock), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
   .compare_match_pulse(compare_match_pulse), .compare_irq(compare_irq));
`default_nettype wire

// *** dv/tcwg_tb.sv ***
// Self-checking bench for the compare waveform generator.
`timescale 1ns/100ps
`default_nettype none
module timer_compare_waveform_gen_tb_top;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, q, v;
   logic [31:0] seed = 32'h0000_003a;
   logic pready, pslverr, compare_irq, err_seen;
   logic [2:0] pin_out, pin_oe, pin_level, compare_match_pulse;
   int errors = 0;
   int checks = 0;
   int hi[3];
   int tg[3];
   int cv[$];
   tcwg_top dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
      .compare_match_pulse(compare_match_pulse), .compare_irq(compare_irq));
   tcwg_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));
   initial begin
      forever #5 clock = ~clock;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int ss_hi(int c, int p);
      return (c > p) ? p + 1 : c;
   endfunction
   function automatic int ds_hi(int c, int p);
      return (c >= p) ? 2 * p : 2 * c;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clock);
      end
      chk("pready", 32'h0000_0001, {31'h0, pready});
      q = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("reg %h", a), e, q & m);
   endtask
   // Stops the counter first so the new setup starts from a clean BOTTOM.
   task automatic cfg(input logic [31:0] ctl, input logic [15:0] per);
      apb(1'b1, tcwg_pkg::OFF_CTRL, 32'h0000_0000);
      apb(1'b1, tcwg_pkg::OFF_COUNT, 32'h0000_0000);
      apb(1'b1, tcwg_pkg::OFF_PERIOD, {16'h0000, per});
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, tcwg_pkg::OFF_COMPARE_VALUE_ZERO + 8'(4 * i), 32'(cv[i]));
      end
      apb(1'b1, tcwg_pkg::OFF_CTRL, ctl);
   endtask
   task automatic run(input int n);
      logic [2:0] prev;
      hi = '{0, 0, 0};
      tg = '{0, 0, 0};
      @(negedge clock);
      prev = pin_out;
      repeat (n) begin
         @(negedge clock);
         for (int i = 0; i < 3; i++) begin
            hi[i] += int'(pin_out[i] === 1'b1);
            tg[i] += int'(pin_out[i] !== prev[i]);
         end
         prev = pin_out;
      end
      @(posedge clock);
   endtask
   initial begin
      #50000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      rd(tcwg_pkg::OFF_PERIOD, 32'hffff_ffff, 32'h0000_ffff);
      rd(tcwg_pkg::OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
      rd(8'h30, 32'hffff_ffff, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, {31'h0, err_seen});
      repeat (4) begin
         v = xs() & 32'h0000_01ff;
         apb(1'b1, tcwg_pkg::OFF_PIN, v);
         chk("pin_level", {29'h0, (v[8:6] & (v[5:3] ^ v[2:0])) | ~v[8:6]}, {29'h0, pin_level});
      end
      apb(1'b1, tcwg_pkg::OFF_PIN, 32'h0000_01c0);
      cv = '{0, 3, 9};
      for (int ps = 0; ps < 2; ps++) begin
         cfg(32'h0000_0721 | 32'(ps << 1), 16'h0007);
         run(16 << ps);
         run(16 << ps);
         for (int i = 0; i < 3; i++) begin
            chk("single", ss_hi(cv[i], 7) * (2 << ps), hi[i]);
         end
      end
      // Lock first so an update between the buffer write and the read cannot hide the flag.
      apb(1'b1, tcwg_pkg::OFF_CTRL, 32'h0000_07a3);
      apb(1'b1, tcwg_pkg::OFF_BUF1, 32'h0000_0005);
      rd(tcwg_pkg::OFF_STATUS, 32'h0000_0038, 32'h0000_0010);
      apb(1'b1, tcwg_pkg::OFF_CTRL, 32'h0000_0723);
      repeat (40) @(posedge clock);
      rd(tcwg_pkg::OFF_STATUS, 32'h0000_0038, 32'h0000_0000);
      rd(tcwg_pkg::OFF_CMP1, 32'hffff_ffff, 32'h0000_0005);
      apb(1'b1, tcwg_pkg::OFF_CTRL, 32'h0000_07a3);
      apb(1'b1, tcwg_pkg::OFF_BUF1, 32'h0000_0002);
      repeat (40) @(posedge clock);
      rd(tcwg_pkg::OFF_CMP1, 32'hffff_ffff, 32'h0000_0005);
      rd(tcwg_pkg::OFF_STATUS, 32'h0000_0038, 32'h0000_0010);
      cv = '{0, 2, 6};
      cfg(32'h0000_0731, 16'h0006);
      run(24);
      run(24);
      for (int i = 0; i < 3; i++) begin
         chk("dual", ds_hi(cv[i], 6) * 2, hi[i]);
      end
      cv = '{3, 1, 2};
      cfg(32'h0000_0711, 16'hffff);
      run(16);
      run(16);
      for (int i = 0; i < 3; i++) begin
         chk("toggles", 16 / (cv[0] + 1), tg[i]);
      end
      apb(1'b1, tcwg_pkg::OFF_INTEN, 32'h0000_0001);
      chk("irq", 32'h0000_0001, {31'h0, compare_irq});
      apb(1'b1, tcwg_pkg::OFF_CTRL, 32'h0000_0000);
      apb(1'b1, tcwg_pkg::OFF_INTEN, 32'h0000_0000);
      chk("irq", 32'h0000_0000, {31'h0, compare_irq});
      apb(1'b1, tcwg_pkg::OFF_STATUS, 32'h0000_0007);
      apb(1'b1, tcwg_pkg::OFF_INTEN, 32'h0000_0001);
      chk("irq", 32'h0000_0000, {31'h0, compare_irq});
      rd(tcwg_pkg::OFF_STATUS, 32'h0000_0007, 32'h0000_0000);
      repeat (4) @(posedge clock);
      wrap_up();
   end
endmodule
`default_nettype wire
